// [verilog/srsc_regs.svh]
// Register offsets, field positions, reset values and timing counts for the reset controller
`ifndef SRSC_REGS_SVH
`define SRSC_REGS_SVH

// Word-aligned byte offsets on the register bus
`define SRSC_OFF_CTRL 8'h00
`define SRSC_OFF_STATUS 8'h04
`define SRSC_OFF_CAUSE 8'h08
`define SRSC_OFF_AHB_GATE 8'h0C
`define SRSC_OFF_APB_GATE 8'h10
`define SRSC_OFF_SCRATCH 8'h14

// Control fields
`define SRSC_CTRL_SWRST 0
`define SRSC_CTRL_OSCSEL 1

// Status fields
`define SRSC_ST_IN_RESET 0
`define SRSC_ST_WDT_EN 1
`define SRSC_ST_CLKSEL 2

// Cause fields, sticky, cleared by writing one
`define SRSC_CAUSE_POR 0
`define SRSC_CAUSE_VMON 1
`define SRSC_CAUSE_PIN 2
`define SRSC_CAUSE_WDT 3
`define SRSC_CAUSE_SW 4

// APB gate positions that stay clocked through reset
`define SRSC_APB_WDT 0
`define SRSC_APB_EMIF 1
`define SRSC_APB_DMAXB 2

// Reset values
`define SRSC_RST_PC 32'h0000_0000
`define SRSC_RST_AHB_GATE 32'hFFFF_FFFF
`define SRSC_RST_APB_GATE 32'h0000_0007

// Oscillator frequencies in kHz and system clock rate
`define SRSC_CLK_KHZ 125000
`define SRSC_LPOSC_KHZ 20000
`define SRSC_LPOSC_DIV_KHZ 2500
// Low power oscillator is modelled as a divided enable of the system clock
`define SRSC_LPOSC_DIV ((`SRSC_CLK_KHZ + `SRSC_LPOSC_KHZ - 1) / `SRSC_LPOSC_KHZ)
`define SRSC_LPOSC_SUB (`SRSC_LPOSC_KHZ / `SRSC_LPOSC_DIV_KHZ)

`endif

// [verilog/srsc_pkg.sv]
// Types shared by the reset controller
package srsc_pkg;

  typedef enum logic [1:0] {
    SRSC_RUN = 2'b00,
    SRSC_HOLD = 2'b01,
    SRSC_EXIT = 2'b10
  } srsc_state_t;

  typedef struct packed {
    logic por;
    logic vmon;
    logic pin;
    logic wdt;
  } srsc_src_t;

  typedef struct packed {
    logic core_halt;
    logic irq_disable;
    logic timer_disable;
    logic regs_reset;
    logic regs_por_reset;
    logic pc_load;
    logic osc_internal;
    logic wdt_enable;
  } srsc_ctl_t;

endpackage

// [verilog/srsc_top.sv]
// Reset state sequencer: source merge, hold actions, exit actions, register slave
//
// What this block does
// R01: Core is halted for the whole time the reset state is active.
// R02: Module registers take defaults on entry; power-on-only bits keep value otherwise.
// R03: All interrupt sources and timer functions are disabled on entry.
// R04: Every high-speed bus peripheral clock gate turns on in reset.
// R05: Peripheral-bus gates turn off except watchdog, memory interface, trigger crossbar.
// R06: Reset never clears or alters on-chip RAM contents.
// R07: Every port output latch set to one, output stage open-drain.
// R08: Weak pull-ups stay enabled during and after reset.
// R09: Power-on and supply-monitor resets drive reset pin low until exit.
// R10: Program counter reloads, fetch starts at address zero on exit.
// R11: Internal oscillator becomes system clock source on exit.
// R12: Low power oscillator default, 20 MHz and 2.5 MHz, auto start/stop. Here ticks come every 7 and 56 system clocks, about 17.9 and 2.2 MHz.
// R13: Watchdog enabled on exit, clocked by low frequency oscillator.
// R14: Any asserted source holds reset; exit only after all are released.
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
`include "srsc_regs.svh"

module srsc_top #(
  parameter int NUM_AHB = 32,
  parameter int NUM_APB = 32,
  parameter int NUM_PORT = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire srsc_pkg::srsc_src_t rst_src,
  input wire logic ram_we_req,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output srsc_pkg::srsc_ctl_t ctl,
  output logic [31:0] pc_reset_value,
  output logic ram_we_allow,
  output logic [NUM_AHB-1:0] ahb_clk_en,
  output logic [NUM_APB-1:0] apb_clk_en,
  output logic [NUM_PORT-1:0] port_latch,
  output logic [NUM_PORT-1:0] port_open_drain,
  output logic [NUM_PORT-1:0] port_pullup_en,
  output logic rst_pin_o,
  output logic rst_pin_oe_n,
  output logic lposc_run,
  output logic lposc_clk_en,
  output logic lposc_div_en,
  output logic wdt_clk_sel_lfo
);
  import srsc_pkg::*;

  srsc_state_t state_ff;
  srsc_state_t nxt_state;
  logic any_src;
  logic drive_pin;
  logic pin_hold_ff;
  logic sw_rst_ff;
  logic osc_sel_ff;
  logic [4:0] cause_ff;
  logic [31:0] scratch_ff;
  logic ack_ff;
  logic [3:0] lp_cnt_ff;
  logic [3:0] lp_sub_ff;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // Every source merged, software request included
  assign any_src = rst_src.por | rst_src.vmon | rst_src.pin | rst_src.wdt | sw_rst_ff; // R14
  assign drive_pin = rst_src.por | rst_src.vmon | pin_hold_ff; // R09

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SRSC_RUN: if (any_src) nxt_state = SRSC_HOLD; // R14
      SRSC_HOLD: if (!any_src) nxt_state = SRSC_EXIT; // R14
      SRSC_EXIT: nxt_state = any_src ? SRSC_HOLD : SRSC_RUN;
      default: nxt_state = SRSC_HOLD;
    endcase
  end

  // Power-up reset starts in the hold state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= SRSC_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Hold and exit controls toward core and peripherals
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= '{core_halt: 1'b1, irq_disable: 1'b1, timer_disable: 1'b1, regs_reset: 1'b1,
               regs_por_reset: 1'b1, pc_load: 1'b0, osc_internal: 1'b1, wdt_enable: 1'b0};
      pc_reset_value <= `SRSC_RST_PC;
    end else begin
      ctl.core_halt <= nxt_state != SRSC_RUN; // R01
      ctl.irq_disable <= nxt_state != SRSC_RUN; // R03
      ctl.timer_disable <= nxt_state != SRSC_RUN; // R03
      ctl.regs_reset <= nxt_state == SRSC_HOLD; // R02
      // Power-on-only bits clear just for a power-on source
      ctl.regs_por_reset <= nxt_state == SRSC_HOLD && rst_src.por; // R02
      ctl.pc_load <= nxt_state == SRSC_EXIT; // R10
      pc_reset_value <= `SRSC_RST_PC; // R10
      if (nxt_state == SRSC_EXIT) begin
        ctl.osc_internal <= 1'b1; // R11
        ctl.wdt_enable <= 1'b1; // R13
      end else if (nxt_state == SRSC_HOLD) begin
        ctl.wdt_enable <= 1'b0;
      end else begin
        ctl.osc_internal <= ~osc_sel_ff;
      end
    end
  end

  // RAM write path only blocked during reset, contents never touched
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ram_we_allow <= 1'b0;
    end else begin
      ram_we_allow <= ram_we_req && nxt_state == SRSC_RUN; // R06
    end
  end

  // Clock gates: forced in reset, software owned while running
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ahb_clk_en <= NUM_AHB'(`SRSC_RST_AHB_GATE);
      apb_clk_en <= NUM_APB'(`SRSC_RST_APB_GATE);
    end else if (nxt_state == SRSC_HOLD) begin
      ahb_clk_en <= '1; // R04
      apb_clk_en <= NUM_APB'(`SRSC_RST_APB_GATE); // R05
    end else if (state_ff == SRSC_RUN && avs_write && ack_ff == 1'b0) begin
      if (hit(avs_address, `SRSC_OFF_AHB_GATE)) begin
        ahb_clk_en <= NUM_AHB'(be_merge(32'(ahb_clk_en), avs_writedata, avs_byteenable));
      end
      if (hit(avs_address, `SRSC_OFF_APB_GATE)) begin
        apb_clk_en <= NUM_APB'(be_merge(32'(apb_clk_en), avs_writedata, avs_byteenable));
      end
    end
  end

  // Port pins: latch high, open-drain, pull-ups always on in reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      port_latch <= '1;
      port_open_drain <= '1;
      port_pullup_en <= '1;
    end else if (nxt_state == SRSC_HOLD) begin
      port_latch <= '1; // R07
      port_open_drain <= '1; // R07
      port_pullup_en <= '1; // R08
    end else begin
      port_pullup_en <= '1; // R08
    end
  end

  // Pin stays low until exit, even when a longer source outlives the power source
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_hold_ff <= 1'b0;
    end else if (nxt_state == SRSC_RUN) begin
      pin_hold_ff <= 1'b0;
    end else if (rst_src.por || rst_src.vmon) begin
      pin_hold_ff <= 1'b1; // R09
    end
  end

  // Reset pin is open-drain: only ever pulls low, never high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_pin_o <= 1'b0;
      rst_pin_oe_n <= 1'b1;
    end else begin
      rst_pin_o <= 1'b0;
      rst_pin_oe_n <= !(drive_pin && nxt_state != SRSC_RUN); // R09
    end
  end

  // Low power oscillator: runs only while it is the selected source
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lposc_run <= 1'b0;
      lp_cnt_ff <= 4'h0;
      lp_sub_ff <= 4'h0;
      lposc_clk_en <= 1'b0;
      lposc_div_en <= 1'b0;
      wdt_clk_sel_lfo <= 1'b1;
    end else begin
      lposc_run <= ctl.osc_internal; // R12
      wdt_clk_sel_lfo <= 1'b1; // R13
      lposc_clk_en <= 1'b0;
      lposc_div_en <= 1'b0;
      if (!lposc_run) begin
        lp_cnt_ff <= 4'h0;
        lp_sub_ff <= 4'h0;
      end else if (lp_cnt_ff == 4'(`SRSC_LPOSC_DIV - 1)) begin
        lp_cnt_ff <= 4'h0;
        lposc_clk_en <= 1'b1; // R12
        if (lp_sub_ff == 4'(`SRSC_LPOSC_SUB - 1)) begin
          lp_sub_ff <= 4'h0;
          lposc_div_en <= 1'b1; // R12
        end else begin
          lp_sub_ff <= lp_sub_ff + 4'h1;
        end
      end else begin
        lp_cnt_ff <= lp_cnt_ff + 4'h1;
      end
    end
  end

  // Software reset request and clock select; cause flags, set wins over clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sw_rst_ff <= 1'b0;
      osc_sel_ff <= 1'b0;
      cause_ff <= 5'h01;
      scratch_ff <= 32'h0000_0000;
    end else begin
      if (state_ff == SRSC_HOLD) begin
        sw_rst_ff <= 1'b0;
        osc_sel_ff <= 1'b0;
      end else if (avs_write && !ack_ff && hit(avs_address, `SRSC_OFF_CTRL)
                   && avs_byteenable[0]) begin
        sw_rst_ff <= avs_writedata[`SRSC_CTRL_SWRST];
        osc_sel_ff <= avs_writedata[`SRSC_CTRL_OSCSEL];
      end
      // Power-on-only contents: cleared by a power-on source, kept by all others
      if (ctl.regs_por_reset) begin
        scratch_ff <= 32'h0000_0000; // R02
      end else if (avs_write && !ack_ff && hit(avs_address, `SRSC_OFF_SCRATCH)) begin
        scratch_ff <= be_merge(scratch_ff, avs_writedata, avs_byteenable);
      end
      for (int i = 0; i < 5; i++) begin
        if (avs_write && !ack_ff && hit(avs_address, `SRSC_OFF_CAUSE) && avs_byteenable[0]
            && avs_writedata[i]) begin
          cause_ff[i] <= 1'b0;
        end
      end
      if (rst_src.por) cause_ff[`SRSC_CAUSE_POR] <= 1'b1;
      if (rst_src.vmon) cause_ff[`SRSC_CAUSE_VMON] <= 1'b1;
      if (rst_src.pin) cause_ff[`SRSC_CAUSE_PIN] <= 1'b1;
      if (rst_src.wdt) cause_ff[`SRSC_CAUSE_WDT] <= 1'b1;
      if (sw_rst_ff) cause_ff[`SRSC_CAUSE_SW] <= 1'b1;
    end
  end

  // Avalon slave: one wait cycle, answer at the second edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_ff <= (avs_read || avs_write) && !ack_ff;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_ff);
      if (avs_read && !ack_ff) begin
        unique case (avs_address)
          `SRSC_OFF_CTRL: avs_readdata <= {30'h0, osc_sel_ff, sw_rst_ff};
          `SRSC_OFF_STATUS: avs_readdata <= {29'h0, ~ctl.osc_internal, ctl.wdt_enable,
                                              state_ff != SRSC_RUN};
          `SRSC_OFF_CAUSE: avs_readdata <= {27'h0, cause_ff};
          `SRSC_OFF_AHB_GATE: avs_readdata <= 32'(ahb_clk_en);
          `SRSC_OFF_APB_GATE: avs_readdata <= 32'(apb_clk_en);
          `SRSC_OFF_SCRATCH: avs_readdata <= scratch_ff;
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  sequence s_src_drop;
    state_ff == SRSC_HOLD && !any_src;
  endsequence

  sequence s_bus_take;
    (avs_read || avs_write) && !ack_ff;
  endsequence

  a_halt_in_reset: assert property (@(posedge clk_sys) disable iff (!rst_n) // R01
    state_ff == SRSC_HOLD |=> ctl.core_halt) else $error("core not halted in reset");
  a_irq_timer_off: assert property (@(posedge clk_sys) disable iff (!rst_n) // R03
    state_ff == SRSC_HOLD |=> ctl.irq_disable && ctl.timer_disable)
    else $error("irq or timer live in reset");
  a_ahb_gates_on: assert property (@(posedge clk_sys) disable iff (!rst_n) // R04
    state_ff == SRSC_HOLD && any_src |=> &ahb_clk_en) else $error("ahb gate off in reset");
  a_apb_gates_keep: assert property (@(posedge clk_sys) disable iff (!rst_n) // R05
    state_ff == SRSC_HOLD && any_src |=> apb_clk_en == NUM_APB'(`SRSC_RST_APB_GATE))
    else $error("apb gates wrong in reset");
  a_port_safe: assert property (@(posedge clk_sys) disable iff (!rst_n) // R07
    state_ff == SRSC_HOLD && any_src |=> &port_latch && &port_open_drain)
    else $error("port not safe in reset");
  a_pullup_on: assert property (@(posedge clk_sys) disable iff (!rst_n) // R08
    ##1 &port_pullup_en) else $error("pullup disabled");
  a_pin_low_por: assert property (@(posedge clk_sys) disable iff (!rst_n) // R09
    rst_src.por || rst_src.vmon |=> !rst_pin_oe_n && !rst_pin_o)
    else $error("reset pin not driven");
  a_pin_held: assert property (@(posedge clk_sys) disable iff (!rst_n) // R09
    pin_hold_ff && state_ff == SRSC_HOLD |=> !rst_pin_oe_n)
    else $error("reset pin released early");
  a_src_enter: assert property (@(posedge clk_sys) disable iff (!rst_n) // R14
    any_src |=> state_ff == SRSC_HOLD) else $error("source did not hold reset");
  a_pc_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // R10
    ctl.pc_load |-> pc_reset_value == `SRSC_RST_PC) else $error("reset vector not zero");
  a_wdt_exit: assert property (@(posedge clk_sys) disable iff (!rst_n) // R13
    ctl.pc_load |-> ctl.wdt_enable && wdt_clk_sel_lfo) else $error("watchdog off at exit");
  a_por_defaults: assert property (@(posedge clk_sys) disable iff (!rst_n) // R02
    rst_src.por |=> ctl.regs_reset && ctl.regs_por_reset)
    else $error("power-on defaults missing");
  a_por_scratch: assert property (@(posedge clk_sys) disable iff (!rst_n) // R02
    ctl.regs_por_reset |=> scratch_ff == 32'h0000_0000)
    else $error("power-on bits kept");
  a_bus_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_bus_take |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");
  a_exit_seq: assert property (@(posedge clk_sys) disable iff (!rst_n) // R14
    s_src_drop |=> ctl.pc_load && ctl.wdt_enable && ctl.osc_internal ##1 !ctl.pc_load)
    else $error("exit actions missing");
  a_ram_blocked: assert property (@(posedge clk_sys) disable iff (!rst_n) // R06
    ctl.core_halt |-> !ram_we_allow) else $error("ram write during reset");
  a_lposc_tick: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
    lposc_div_en |-> lposc_clk_en) else $error("lposc divided tick wrong");
  // Run may drop on the tick edge itself, so stopping is checked one edge on
  a_lposc_stop: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
    !lposc_run |=> !lposc_clk_en && !lposc_div_en) else $error("lposc ticks while stopped");

endmodule

// [bench/srsc_core_model.sv]
// Far-side model: core issuing RAM writes and the pulled-up reset pin
`timescale 1ns/10ps
module srsc_core_model (
  input wire logic clk_sys,
  input wire logic ram_we_allow,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe_n,
  output logic ram_we_req,
  output logic rst_pin_lvl,
  output int wr_count
);
  initial begin
    ram_we_req = 1'b0;
    wr_count = 0;
  end
  // Core keeps asking; only granted writes land, so a reset never alters stored data
  always @(posedge clk_sys) begin
    ram_we_req <= ~ram_we_req;
    if (ram_we_allow === 1'b1) begin
      wr_count <= wr_count + 1;
    end
  end
  // Board pull-up wins once the pin is released
  assign rst_pin_lvl = rst_pin_oe_n ? 1'b1 : rst_pin_o;
endmodule

// [bench/tb.sv]
// Self-checking bench for the reset state sequencer
`timescale 1ns/10ps
`include "srsc_regs.svh"
module tb;
  import srsc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  srsc_src_t rst_src = '0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata, pc_reset_value, ahb_clk_en, apb_clk_en, rd;
  logic [15:0] port_latch, port_open_drain, port_pullup_en;
  logic ram_we_req, ram_we_allow, rst_pin_o, rst_pin_oe_n, rst_pin_lvl;
  logic avs_waitrequest, lposc_run, lposc_clk_en, lposc_div_en, wdt_clk_sel_lfo;
  srsc_ctl_t ctl;
  int mismatches = 0;
  int compares = 0;
  int seed = 4;
  int wr_count, k, c0, c1, exp_cause, exp_scratch, exp_ahb;

  srsc_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .rst_src(rst_src),
    .ram_we_req(ram_we_req), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ctl(ctl), .pc_reset_value(pc_reset_value),
    .ram_we_allow(ram_we_allow), .ahb_clk_en(ahb_clk_en), .apb_clk_en(apb_clk_en),
    .port_latch(port_latch), .port_open_drain(port_open_drain),
    .port_pullup_en(port_pullup_en), .rst_pin_o(rst_pin_o), .rst_pin_oe_n(rst_pin_oe_n),
    .lposc_run(lposc_run), .lposc_clk_en(lposc_clk_en), .lposc_div_en(lposc_div_en),
    .wdt_clk_sel_lfo(wdt_clk_sel_lfo));

  srsc_core_model partner (.clk_sys(clk_sys), .ram_we_allow(ram_we_allow),
    .rst_pin_o(rst_pin_o), .rst_pin_oe_n(rst_pin_oe_n), .ram_we_req(ram_we_req),
    .rst_pin_lvl(rst_pin_lvl), .wr_count(wr_count));

  always #4 clk_sys = ~clk_sys;

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic give_up(input string what);
    mismatches++;
    $display("CHECK FAILED t=%0t timeout %s", $time, what);
    tally_and_finish();
  endtask

  // Entered just after a rising edge; leaves one idle edge so no signal is set twice
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int i;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) give_up("bus");
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wait_exit;
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (ctl.pc_load === 1'b1) break;
    end
    if (i == 20) give_up("exit");
    check(pc_reset_value, `SRSC_RST_PC, "pc value");
    @(posedge clk_sys);
    check(ctl.pc_load, 1'b0, "pc pulse width");
    check(ctl.core_halt, 1'b0, "core runs");
    check({ctl.irq_disable, ctl.timer_disable}, 2'b00, "irq timer on");
    check(ctl.osc_internal, 1'b1, "internal osc");
    check({ctl.wdt_enable, wdt_clk_sel_lfo}, 2'b11, "wdt on lfo");
    check(port_pullup_en, 16'hFFFF, "pullups after");
  endtask

  task automatic hold_checks(input logic drives_pin);
    repeat (3) @(posedge clk_sys);
    check(ctl.core_halt, 1'b1, "halt");
    check({ctl.irq_disable, ctl.timer_disable}, 2'b11, "irq timer off");
    check(ahb_clk_en, `SRSC_RST_AHB_GATE, "ahb gates");
    check(apb_clk_en, `SRSC_RST_APB_GATE, "apb gates");
    check({port_latch, port_open_drain}, 32'hFFFF_FFFF, "port safe");
    check(port_pullup_en, 16'hFFFF, "pullups");
    check(ram_we_allow, 1'b0, "ram frozen");
    check(rst_pin_lvl, !drives_pin, "reset pin");
    check({ctl.regs_reset, ctl.regs_por_reset}, {1'b1, k == 0}, "register defaults");
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    check(ctl.core_halt, 1'b1, "halt in reset");
    check(ahb_clk_en, `SRSC_RST_AHB_GATE, "ahb in reset");
    check(apb_clk_en, `SRSC_RST_APB_GATE, "apb in reset");
    rst_n <= 1'b1;
    wait_exit();
    bus(1'b0, `SRSC_OFF_STATUS, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_0002, "status run");
    bus(1'b0, 8'h40, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_0000, "unmapped");
    bus(1'b1, `SRSC_OFF_APB_GATE, 32'hFFFF_FFFF, 4'h1);
    check(apb_clk_en, 32'h0000_00FF, "apb lane");
    exp_scratch = $random(seed);
    bus(1'b1, `SRSC_OFF_SCRATCH, exp_scratch, 4'hF);
    exp_cause = 1;
    for (k = 0; k < 4; k++) begin
      exp_ahb = $random(seed);
      bus(1'b1, `SRSC_OFF_AHB_GATE, exp_ahb, 4'hF);
      bus(1'b1, `SRSC_OFF_APB_GATE, 32'h0000_0000, 4'hF);
      check(ahb_clk_en, exp_ahb, "ahb write");
      check(apb_clk_en, 32'h0000_0000, "apb write");
      // Watchdog source overlaps the power-on, supply-monitor and pin sources in turn, then runs alone
      rst_src <= (4'b1000 >> k) | 4'b0001;
      hold_checks(k < 2);
      c0 = wr_count;
      repeat (4) @(posedge clk_sys);
      check(wr_count, c0, "ram kept");
      rst_src <= 4'b0001;
      repeat (3) @(posedge clk_sys);
      check(ctl.core_halt, 1'b1, "still held");
      check(rst_pin_lvl, k >= 2, "pin until exit");
      rst_src <= 4'b0000;
      wait_exit();
      exp_cause = exp_cause | (1 << k) | 8;
      bus(1'b0, `SRSC_OFF_CAUSE, 32'h0000_0000, 4'hF);
      check(rd, exp_cause, "cause");
      bus(1'b1, `SRSC_OFF_CAUSE, 32'h0000_001F, 4'h1);
      exp_cause = 0;
      bus(1'b0, `SRSC_OFF_AHB_GATE, 32'h0000_0000, 4'hF);
      check(rd, `SRSC_RST_AHB_GATE, "ahb default");
      bus(1'b0, `SRSC_OFF_SCRATCH, 32'h0000_0000, 4'hF);
      check(rd, (k == 0) ? 0 : exp_scratch, "power-on-only bits");
      exp_scratch = $random(seed);
      bus(1'b1, `SRSC_OFF_SCRATCH, exp_scratch, 4'hF);
    end
    bus(1'b1, `SRSC_OFF_CTRL, 32'h0000_0002, 4'h1);
    bus(1'b0, `SRSC_OFF_STATUS, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_0006, "status external clock");
    check(lposc_run, 1'b0, "lposc stopped");
    // Software reset with the external clock still selected
    bus(1'b1, `SRSC_OFF_CTRL, 32'h0000_0003, 4'h1);
    wait_exit();
    bus(1'b0, `SRSC_OFF_CAUSE, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_0010, "software cause");
    check(wr_count > c0, 1'b1, "ram writes resume");
    c0 = 0;
    c1 = 0;
    repeat (112) begin
      @(posedge clk_sys);
      if (lposc_clk_en === 1'b1) c0++;
      if (lposc_div_en === 1'b1) c1++;
    end
    check(c0, 16, "lposc rate");
    check(c1, 2, "lposc divided rate");
    tally_and_finish();
  end
endmodule
